// ==== src/power_save_mode_controller.sv ====
`timescale 1ns/1ps
// power save mode controller: start-up state, nap depths, deep modes
// assumes synchronous inputs, wake/reset sources already qualified
module power_save_mode_controller (
    // clock, reset, enable
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    // supply monitors and reset sources
    input  wire logic        i_analog_supply_power_on_reset,
    input  wire logic        i_reset_source,
    // processor requests
    input  wire logic        i_wfi,
    input  wire logic        i_handler_return_lowest,
    // software mode selection
    input  wire logic [1:0]  i_nap_depth_field,
    input  wire logic        i_deep_nap_select,
    input  wire logic        i_nap_on_handler_return,
    input  wire logic        i_retention_select_bit,
    input  wire logic        i_backup_select_bit,
    input  wire logic [1:0]  i_run_state,
    input  wire logic        i_crystal_low_freq_osc_en,
    input  wire logic        i_rc_low_freq_osc_en,
    input  wire logic        i_fast_src_en,
    // wake inputs
    input  wire logic        i_irq_cpu_clocked,
    input  wire logic        i_irq_ahb_clocked,
    input  wire logic        i_irq_apb_clocked,
    input  wire logic        i_irq_fast_clocked,
    input  wire logic        i_async_wake,
    // peripheral clock masks
    input  wire logic [31:0] i_high_speed_bus_clock_mask,
    input  wire logic [31:0] i_peripheral_bus_clock_mask,
    // clock and power controls
    output logic             o_cpu_clk_en,
    output logic [31:0]      o_ahb_clk_en,
    output logic [31:0]      o_apb_clk_en,
    output logic             o_generic_clock_outputs_en,
    output logic             o_fast_src_en,
    output logic             o_fll_en,
    output logic             o_pll_en,
    output logic             o_system_rc_oscillator_en,
    output logic             o_sys_clk_is_rc,
    output logic [3:0]       o_clk_div,
    output logic             o_crystal_low_freq_osc_run,
    output logic             o_rc_low_freq_osc_run,
    output logic             o_core_power_on,
    output logic             o_logic_retain,
    output logic             o_io_config_hold,
    // resets and status
    output logic             o_chip_reset_n,
    output logic             o_core_reset_n,
    output logic             o_cpu_halt,
    output logic [31:0]      o_boot_addr,
    output logic [1:0]       o_run_state,
    output logic             o_backup_wake_flag,
    output logic [2:0]       o_mode
);
    psm_pkg::psm_state_e state_ff;
    psm_pkg::psm_state_e nxt_state;
    logic [1:0]          run_state_ff;
    logic [3:0]          rst_cnt_ff;
    logic                backup_select_bit_flag_ff;
    logic                por_ff;
    logic [1:0]          cap_depth;
    logic [2:0]          cap_sel;
    logic [1:0]          cap_low_osc;
    logic                sleep_req;
    logic                accept;
    logic                wake;
    logic                nap_wake;
    logic                depth_ahb_off;
    logic                depth_apb_off;
    logic                depth_fast_off;
    logic                deep_gate;
    logic                low_power;

    assign sleep_req = i_wfi
                     | (i_handler_return_lowest & i_nap_on_handler_return);
    assign accept    = (state_ff == psm_pkg::ST_RUN) && sleep_req;

    // mode bits captured once per entry
    psm_hold_reg #(.W(2), .RST(psm_pkg::NAP_DEPTH_CPU)) u_depth (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_load  (accept),
        .i_d     (i_nap_depth_field),
        .o_q     (cap_depth)
    );
    psm_hold_reg #(.W(3), .RST(3'h0)) u_sel (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_load  (accept),
        .i_d     ({i_deep_nap_select, i_retention_select_bit, i_backup_select_bit}),
        .o_q     (cap_sel)
    );
    psm_hold_reg #(.W(2), .RST(2'h0)) u_low_osc (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_load  (accept),
        .i_d     ({i_crystal_low_freq_osc_en, i_rc_low_freq_osc_en}),
        .o_q     (cap_low_osc)
    );

    // only interrupts whose clock still runs at the chosen depth
    always_comb begin
        unique case (cap_depth)
            psm_pkg::NAP_DEPTH_CPU: nap_wake = i_irq_cpu_clocked | i_irq_ahb_clocked
                                             | i_irq_apb_clocked | i_irq_fast_clocked;
            psm_pkg::NAP_DEPTH_AHB: nap_wake = i_irq_apb_clocked | i_irq_fast_clocked;
            psm_pkg::NAP_DEPTH_APB: nap_wake = i_irq_fast_clocked;
            psm_pkg::NAP_DEPTH_FAST: nap_wake = 1'b0;
        endcase
    end
    assign wake = (state_ff == psm_pkg::ST_NAP) ? (nap_wake | i_async_wake) : i_async_wake;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            psm_pkg::ST_RUN: begin
                if (sleep_req) begin
                    if (!i_deep_nap_select) begin
                        nxt_state = psm_pkg::ST_NAP;
                    end else if (i_backup_select_bit) begin
                        nxt_state = psm_pkg::ST_BACKUP;
                    end else if (i_retention_select_bit) begin
                        nxt_state = psm_pkg::ST_RETAIN;
                    end else begin
                        nxt_state = psm_pkg::ST_WAIT;
                    end
                end
            end
            psm_pkg::ST_NAP,
            psm_pkg::ST_WAIT,
            psm_pkg::ST_RETAIN: begin
                if (wake) begin
                    nxt_state = psm_pkg::ST_RUN;
                end
            end
            psm_pkg::ST_BACKUP: begin
                if (i_async_wake) begin
                    nxt_state = psm_pkg::ST_CORE_RST;
                end
            end
            psm_pkg::ST_CORE_RST: begin
                if (rst_cnt_ff == psm_pkg::CORE_RST_CYCLES) begin
                    nxt_state = psm_pkg::ST_RUN;
                end
            end
            default: nxt_state = psm_pkg::ST_RUN;
        endcase
    end

    // analog supply monitor never masked by any mode
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            por_ff <= 1'b1;
        end else begin
            por_ff <= i_analog_supply_power_on_reset;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff <= psm_pkg::ST_RUN;
        end else if (por_ff || i_reset_source) begin
            state_ff <= psm_pkg::ST_RUN;
        end else if (i_ce) begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            run_state_ff <= psm_pkg::RUN_STATE_INIT;
        end else if (por_ff || i_reset_source) begin
            run_state_ff <= psm_pkg::RUN_STATE_INIT;
        end else if (i_ce && state_ff == psm_pkg::ST_RUN) begin
            run_state_ff <= i_run_state;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_cnt_ff <= 4'h0;
        end else if (i_ce) begin
            if (state_ff == psm_pkg::ST_CORE_RST) begin
                rst_cnt_ff <= rst_cnt_ff + 4'h1;
            end else begin
                rst_cnt_ff <= 4'h0;
            end
        end
    end

    // reset wins: set is blocked while por_ff or i_reset_source is high, and either clears the flag
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            backup_select_bit_flag_ff <= 1'b0;
        end else if (i_ce && state_ff == psm_pkg::ST_BACKUP && i_async_wake
                     && !por_ff && !i_reset_source) begin
            backup_select_bit_flag_ff <= 1'b1;
        end else if (por_ff || i_reset_source) begin
            backup_select_bit_flag_ff <= 1'b0;
        end
    end

    assign low_power      = (state_ff != psm_pkg::ST_RUN);
    assign deep_gate      = (state_ff == psm_pkg::ST_WAIT) || (state_ff == psm_pkg::ST_RETAIN)
                          || (state_ff == psm_pkg::ST_BACKUP)
                          || (state_ff == psm_pkg::ST_CORE_RST);
    assign depth_ahb_off  = (state_ff == psm_pkg::ST_NAP) && (cap_depth >= psm_pkg::NAP_DEPTH_AHB);
    assign depth_apb_off  = (state_ff == psm_pkg::ST_NAP) && (cap_depth >= psm_pkg::NAP_DEPTH_APB);
    assign depth_fast_off = (state_ff == psm_pkg::ST_NAP) && (cap_depth == psm_pkg::NAP_DEPTH_FAST);

    assign o_cpu_clk_en  = !low_power;
    assign o_cpu_halt    = low_power;
    assign o_ahb_clk_en  = (depth_ahb_off || deep_gate) ? 32'h0
                         : i_high_speed_bus_clock_mask;
    assign o_apb_clk_en  = (depth_apb_off || deep_gate) ? 32'h0
                         : i_peripheral_bus_clock_mask;
    assign o_generic_clock_outputs_en = !(depth_apb_off || deep_gate);
    assign o_fast_src_en = i_fast_src_en && !depth_fast_off && !deep_gate;
    assign o_fll_en      = o_fast_src_en && (run_state_ff != psm_pkg::RUN_STATE_INIT);
    assign o_pll_en      = o_fll_en;
    assign o_system_rc_oscillator_en = !deep_gate;
    assign o_sys_clk_is_rc = (run_state_ff == psm_pkg::RUN_STATE_INIT);
    assign o_clk_div     = psm_pkg::CLK_DIV_NONE;
    assign o_crystal_low_freq_osc_run = low_power ? cap_low_osc[1]
                                      : i_crystal_low_freq_osc_en;
    assign o_rc_low_freq_osc_run      = low_power ? cap_low_osc[0]
                                      : i_rc_low_freq_osc_en;
    assign o_core_power_on  = (state_ff != psm_pkg::ST_BACKUP);
    assign o_logic_retain   = (state_ff == psm_pkg::ST_RETAIN);
    assign o_io_config_hold = low_power;
    assign o_chip_reset_n   = !por_ff;
    assign o_core_reset_n   = !por_ff && (state_ff != psm_pkg::ST_CORE_RST)
                            && (state_ff != psm_pkg::ST_BACKUP);
    assign o_boot_addr      = psm_pkg::RESET_VECTOR_ADDR;
    assign o_run_state      = run_state_ff;
    assign o_backup_wake_flag = backup_select_bit_flag_ff;
    assign o_mode           = 3'(state_ff);
endmodule

// ==== src/psm_hold_reg.sv ====
`timescale 1ns/1ps
// one held register with load enable, used for captured mode bits
// assumes clock enable freezes it like the rest of the block
module psm_hold_reg #(
    parameter int          W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_ce,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_q <= RST;
        end else if (i_ce && i_load) begin
            o_q <= i_d;
        end
    end
endmodule

// ==== src/psm_pkg.sv ====
// constants, modes and states of the power save mode controller
// assumes one 100 MHz clock; no register bus, all control bits are ports
package psm_pkg;
    typedef enum logic [2:0] {
        ST_RUN,
        ST_NAP,
        ST_WAIT,
        ST_RETAIN,
        ST_BACKUP,
        ST_CORE_RST
    } psm_state_e;

    localparam logic [31:0] RESET_VECTOR_ADDR = 32'h0000_0000;
    localparam logic [1:0]  RUN_STATE_INIT    = 2'h0;
    localparam logic [1:0]  NAP_DEPTH_CPU     = 2'h0;
    localparam logic [1:0]  NAP_DEPTH_AHB     = 2'h1;
    localparam logic [1:0]  NAP_DEPTH_APB     = 2'h2;
    localparam logic [1:0]  NAP_DEPTH_FAST    = 2'h3;
    localparam logic [3:0]  CLK_DIV_NONE      = 4'h0;
    localparam int          CORE_RST_NS       = 100;
    localparam int          CLK_PERIOD_NS     = 10;
    localparam logic [3:0]  CORE_RST_CYCLES   =
        4'((CORE_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

// ==== verification/psm_cpu_model.sv ====
// processor core model: sets mode bits, then asks for sleep
// assumes the bench calls its tasks between clock edges
`timescale 1ns/1ps
module psm_cpu_model (
    input  wire logic  i_clk,
    output logic       o_wfi = 0,
    output logic       o_hret = 0,
    output logic [5:0] o_sel = 0
);
    // sel: handler-return path, deep, retention, backup, depth
    task automatic set(input logic [5:0] s);
        @(posedge i_clk);
        #1 o_sel = s;
    endtask
    task automatic sleep(input logic [5:0] s);
        set(s);
        @(posedge i_clk);
        #1 {o_hret, o_wfi} = {s[5], !s[5]};
        @(posedge i_clk);
        #1 {o_hret, o_wfi} = 2'h0;
    endtask
endmodule

// ==== verification/psm_sva.sv ====
// port checker for the power save mode controller
// assumes bound to the controller, one clock domain
`timescale 1ns/1ps
module psm_sva (
    input wire logic        i_clk, i_rst_n, i_ce, i_wfi, i_deep_nap_select,
    input wire logic        i_analog_supply_power_on_reset, i_reset_source,
    input wire logic        i_retention_select_bit, i_backup_select_bit, i_async_wake,
    input wire logic        i_fast_src_en,
    input wire logic [1:0]  i_nap_depth_field, o_run_state,
    input wire logic [31:0] i_high_speed_bus_clock_mask, o_ahb_clk_en, o_apb_clk_en,
    input wire logic [31:0] o_boot_addr,
    input wire logic [3:0]  o_clk_div,
    input wire logic [2:0]  o_mode,
    input wire logic        o_cpu_halt, o_cpu_clk_en, o_fast_src_en, o_fll_en, o_pll_en,
    input wire logic        o_generic_clock_outputs_en, o_system_rc_oscillator_en,
    input wire logic        o_core_power_on, o_logic_retain, o_io_config_hold,
    input wire logic        o_chip_reset_n, o_core_reset_n, o_backup_wake_flag,
    input wire logic        o_sys_clk_is_rc
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire logic quiet = i_ce && !i_reset_source && !i_analog_supply_power_on_reset;
    wire logic go = quiet && o_chip_reset_n && o_mode == 3'h0 && i_wfi;
    nap_entry_a: assert property (go && !i_deep_nap_select |=> o_mode == 3'h1)
        else $error("nap not entered");
    deep_entry_a: assert property (go && i_deep_nap_select |=> o_mode ==
        ($past(i_backup_select_bit) ? 3'h4 : $past(i_retention_select_bit) ? 3'h3 : 3'h2))
        else $error("wrong deep mode");
    depth_top_a: assert property (go && !i_deep_nap_select && i_nap_depth_field == 2'h3 |=>
        o_ahb_clk_en == 32'h0 && o_apb_clk_en == 32'h0 && !o_generic_clock_outputs_en
        && !o_fast_src_en && o_system_rc_oscillator_en) else $error("depth 3 gating");
    depth_zero_a: assert property (go && !i_deep_nap_select && i_nap_depth_field == 2'h0 |=>
        !o_cpu_clk_en && o_ahb_clk_en == $past(i_high_speed_bus_clock_mask))
        else $error("depth 0 gating");
    wait_gate_a: assert property (o_mode inside {3'h2, 3'h3} |-> !o_cpu_clk_en &&
        o_ahb_clk_en == 32'h0 && o_apb_clk_en == 32'h0 && !o_fast_src_en && !o_pll_en
        && (o_mode == 3'h2 || o_logic_retain)) else $error("wait gating");
    save_hold_a: assert property (o_mode inside {[3'h1:3'h4]} |-> o_io_config_hold && o_cpu_halt)
        else $error("save mode hold");
    backup_power_a: assert property (o_mode == 3'h4 |-> !o_core_power_on)
        else $error("core powered in backup");
    backup_wake_a: assert property (o_mode == 3'h4 && quiet && i_async_wake |=> o_mode == 3'h5
        && o_backup_wake_flag && !o_core_reset_n ##[1:12] o_mode == 3'h0 && o_core_reset_n)
        else $error("backup wake");
    nap_refuse_a: assert property (o_mode == 3'h1 && i_fast_src_en && !o_fast_src_en && quiet
        && !i_async_wake |=> o_mode == 3'h1) else $error("depth 3 woke");
    wake_return_a: assert property (o_mode inside {[3'h1:3'h3]} && quiet && i_async_wake |=>
        o_mode == 3'h0 && o_run_state == $past(o_run_state)) else $error("wake return");
    reset_exit_a: assert property (i_reset_source || !o_chip_reset_n |=>
        o_mode == 3'h0 && o_run_state == 2'h0 && !o_backup_wake_flag) else $error("reset exit");
    supply_reset_a: assert property (1'b1 |=> o_chip_reset_n ==
        !$past(i_analog_supply_power_on_reset)) else $error("supply reset");
    startup_a: assert property (o_run_state == 2'h0 |-> o_sys_clk_is_rc && !o_fll_en &&
        !o_pll_en && o_clk_div == 4'h0 && o_boot_addr == 32'h0) else $error("start-up state");
endmodule
bind power_save_mode_controller psm_sva u_sva (.*);

// ==== verification/testbench.sv ====
// self-checking bench for the power save mode controller
// assumes the core model drives the request and selection bits
`timescale 1ns/1ps
module testbench;
    logic i_clk = 0, i_rst_n = 0, i_ce = 1, i_analog_supply_power_on_reset = 0;
    logic i_reset_source = 0, i_async_wake = 0, i_crystal_low_freq_osc_en = 0;
    logic i_rc_low_freq_osc_en = 1, i_fast_src_en = 1, i_irq_cpu_clocked = 0;
    logic i_irq_ahb_clocked = 0, i_irq_apb_clocked = 0, i_irq_fast_clocked = 0;
    logic [1:0] i_run_state = 0, rs, o_run_state;
    logic [31:0] i_high_speed_bus_clock_mask = 0, i_peripheral_bus_clock_mask = 0;
    logic [31:0] o_ahb_clk_en, o_apb_clk_en, o_boot_addr;
    logic [3:0] o_clk_div, irq;
    logic [2:0] o_mode;
    logic i_wfi, i_handler_return_lowest, o_cpu_clk_en, o_generic_clock_outputs_en;
    logic o_fast_src_en, o_fll_en, o_pll_en, o_system_rc_oscillator_en, o_sys_clk_is_rc;
    logic o_crystal_low_freq_osc_run, o_rc_low_freq_osc_run, o_core_power_on;
    logic o_logic_retain, o_io_config_hold, o_chip_reset_n, o_core_reset_n;
    logic o_cpu_halt, o_backup_wake_flag, i_nap_on_handler_return, i_deep_nap_select;
    logic i_retention_select_bit, i_backup_select_bit, xen;
    logic [1:0] i_nap_depth_field;
    integer err_total = 0, checks = 0, seed = 17134, n, k, t;
    logic [5:0] sel;
    psm_cpu_model cpu (.i_clk(i_clk), .o_wfi(i_wfi), .o_hret(i_handler_return_lowest),
        .o_sel(sel));
    assign {i_nap_on_handler_return, i_deep_nap_select, i_retention_select_bit,
        i_backup_select_bit, i_nap_depth_field} = sel;
    power_save_mode_controller DUT (.*);
    always #5 i_clk = ~i_clk;
    task tick;
        @(posedge i_clk);
        #1;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task close_out;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // expected nap wake by clock group still running, irq = fast, apb, ahb, cpu
    function logic wakes(input integer d, input logic [3:0] q);
        return d == 0 ? |q : d == 1 ? |q[3:2] : d == 2 ? q[3] : 1'b0;
    endfunction
    initial begin
        #100000;
        err_total++;
        close_out;
    end
    initial begin
        repeat (2) @(posedge i_clk);
        #1 i_rst_n = 1;
        tick;
        tick;
        chk("mode", 0, o_mode);
        chk("rc", 1, o_sys_clk_is_rc);
        chk("loops", 0, {o_fll_en, o_pll_en, o_clk_div});
        chk("boot", 0, o_boot_addr);
        for (n = 0; n < 24; n++) begin
            rs = $random(seed);
            irq = (n < 8) ? 4'h1 << n[1:0] : $random(seed);
            xen = $random(seed);
            {i_run_state, i_crystal_low_freq_osc_en, i_rc_low_freq_osc_en} = {rs, xen, !xen};
            i_high_speed_bus_clock_mask = $random(seed);
            i_peripheral_bus_clock_mask = $random(seed);
            cpu.sleep({n[2], 3'h0, n[1:0]});
            chk("nap", 1, o_mode);
            chk("cpu", 0, o_cpu_clk_en);
            chk("ahb", n[1:0] ? 0 : i_high_speed_bus_clock_mask, o_ahb_clk_en);
            chk("apb", n[1:0] > 1 ? 0 : i_peripheral_bus_clock_mask, o_apb_clk_en);
            chk("fast", n[1:0] < 3, o_fast_src_en);
            {i_crystal_low_freq_osc_en, i_rc_low_freq_osc_en} = {!xen, xen};
            i_run_state = ~rs;
            {i_irq_fast_clocked, i_irq_apb_clocked, i_irq_ahb_clocked, i_irq_cpu_clocked} = irq;
            tick;
            {i_irq_fast_clocked, i_irq_apb_clocked, i_irq_ahb_clocked, i_irq_cpu_clocked} = 0;
            chk("irq wake", !wakes(n[1:0], irq), o_mode);
            k = (o_mode === 3'h1);
            if (k) chk("low osc", {xen, !xen}, {o_crystal_low_freq_osc_run, o_rc_low_freq_osc_run});
            chk("run held", rs, o_run_state);
            i_async_wake = 1;
            tick;
            i_async_wake = 0;
            chk("run", {3'h0, k ? rs : ~rs}, {o_mode, o_run_state});
        end
        for (k = 0; k < 3; k++) begin
            i_run_state = k + 1;
            cpu.sleep({2'h1, k == 1, k == 2, 2'h3});
            chk("deep", 2 + k, o_mode);
            chk("core on", k != 2, o_core_power_on);
            chk("retain", k == 1, o_logic_retain);
            chk("hold", 1, o_io_config_hold);
            cpu.set(6'h0);
            chk("held", 2 + k, o_mode);
            i_run_state = ~i_run_state;
            i_async_wake = 1;
            tick;
            i_async_wake = 0;
            if (k == 2) chk("core rst", 5'h16, {o_mode, o_backup_wake_flag, o_core_reset_n});
            for (t = 0; t < 20 && o_mode !== 3'h0; t++) tick;
            chk("wake cycles", k == 2 ? psm_pkg::CORE_RST_CYCLES + 1 : 0, t);
            chk("back", k + 1, {o_mode, o_run_state});
        end
        i_run_state = 2;
        cpu.sleep(6'h10);
        i_reset_source = 1;
        tick;
        i_reset_source = 0;
        chk("rst exit", 0, {o_mode, o_run_state, o_backup_wake_flag});
        i_analog_supply_power_on_reset = 1;
        tick;
        i_analog_supply_power_on_reset = 0;
        chk("chip rst", 0, o_chip_reset_n);
        tick;
        chk("chip run", 3'h4, {o_chip_reset_n, o_run_state});
        close_out;
    end
endmodule
